// file: design/atc_pkg.sv
package atc_pkg;

  // Register offsets on the codec control port.
  localparam logic [6:0] ATC_LEFT_DECAY_OFS = 7'h68;
  localparam logic [6:0] ATC_RIGHT_ATTACK_OFS = 7'h69;

  // Field positions shared by both timing registers.
  localparam int ATC_SEL_BIT = 7;
  localparam int ATC_BASE_LSB = 5;
  localparam int ATC_MULT_LSB = 2;

  // Value of every timing register, the read data and the effective times after reset.
  localparam logic [7:0] ATC_CFG_RST = 8'h00;
  localparam logic [7:0] ATC_RDATA_RST = 8'h00;
  localparam logic [15:0] ATC_TIME_RST = 16'h0000;

  // Baseline times in milliseconds, indexed by the 2-bit code.
  localparam logic [15:0] ATC_DECAY_BASE_MS [0:3] =
    '{16'h0032, 16'h0096, 16'h00fa, 16'h015e};
  localparam logic [15:0] ATC_ATTACK_BASE_MS [0:3] =
    '{16'h0007, 16'h0008, 16'h000a, 16'h000b};

  // Longest decay time in milliseconds per decimation ratio code.
  // Code 0 is ratio 1, and each step adds one half up to code 10 (ratio 6).
  localparam logic [3:0] ATC_RATIO_LAST = 4'ha;
  localparam logic [15:0] ATC_DECAY_CAP_MS [0:10] =
    '{16'h0fa0, 16'h15e0, 16'h1f40, 16'h2580, 16'h2bc0, 16'h2bc0,
      16'h3e80, 16'h3e80, 16'h4b00, 16'h5780, 16'h5780};

  // Cap for a ratio code; unused codes take the cap of the largest ratio.
  function automatic logic [15:0] atc_cap_ms(input logic [3:0] ratio);
    if (ratio > ATC_RATIO_LAST) begin
      return ATC_DECAY_CAP_MS[ATC_RATIO_LAST];
    end
    return ATC_DECAY_CAP_MS[ratio];
  endfunction

  // Smaller of a decay time and the cap for the given ratio.
  function automatic logic [15:0] atc_limit(input logic [15:0] t,
                                            input logic [3:0] ratio);
    logic [15:0] cap;
    cap = atc_cap_ms(ratio);
    return (t > cap) ? cap : t;
  endfunction

endpackage

// file: design/atc_calc_if.sv
// Carries the programmed codes to the time calculator and the times back.
interface atc_calc_if;
  import atc_pkg::*;
  logic [1:0] decay_base; // Left baseline decay code.
  logic [2:0] decay_mult; // Left decay multiplier code.
  logic [1:0] attack_base; // Right baseline attack code.
  logic [2:0] attack_mult; // Right attack multiplier code.
  logic [15:0] decay_ms; // Programmed decay time before the cap.
  logic [15:0] attack_ms; // Programmed attack time.

  modport regs (
    output decay_base,
    output decay_mult,
    output attack_base,
    output attack_mult,
    input decay_ms,
    input attack_ms
  );

  modport calc (
    input decay_base,
    input decay_mult,
    input attack_base,
    input attack_mult,
    output decay_ms,
    output attack_ms
  );
endinterface

// file: design/atc_time_calc.sv
module atc_time_calc
  import atc_pkg::*;
(
  atc_calc_if.calc tc
);

  ////////////////////////////////////////////////////////////////////////////
  // Time is baseline times two to the multiplier code, a plain shift.
  // The largest product, 350 ms by 128, still fits in 16 bits, so the
  // shift never loses a bit and no saturation is needed here.
  always_comb begin
    tc.decay_ms = ATC_DECAY_BASE_MS[tc.decay_base] << tc.decay_mult;
    tc.attack_ms = ATC_ATTACK_BASE_MS[tc.attack_base] << tc.attack_mult;
  end

endmodule

// file: design/atc_regs.sv
module atc_regs
  import atc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // Codec control port, one byte per access.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Times produced by the legacy AGC registers, in milliseconds.
  input wire logic [15:0] legacy_left_decay_ms,
  input wire logic [15:0] legacy_right_attack_ms,
  // Decimation ratio code, 0 for ratio 1 up to 10 for ratio 6.
  input wire logic [3:0] adc_decimation_ratio,
  // Effective time constants handed to the AGC engines.
  output logic [15:0] left_decay_ms,
  output logic [15:0] right_attack_ms
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the block, all in one record.
  typedef struct packed {
    logic [7:0] left_cfg; // Left decay timing register.
    logic [7:0] right_cfg; // Right attack timing register.
    logic [7:0] rdata; // Read data held for the host.
    logic [15:0] left_decay; // Effective left decay time.
    logic [15:0] right_attack; // Effective right attack time.
  } atc_state_s;

  atc_state_s state_ff; // Registered state.
  atc_state_s nxt_state; // Next state.
  atc_calc_if tc (); // Link to the time calculator.
  logic [15:0] left_pick; // Left decay before the cap.

  ////////////////////////////////////////////////////////////////////////////
  // The calculator works only on the stored codes.
  assign tc.decay_base = state_ff.left_cfg[ATC_BASE_LSB +: 2];
  assign tc.decay_mult = state_ff.left_cfg[ATC_MULT_LSB +: 3];
  assign tc.attack_base = state_ff.right_cfg[ATC_BASE_LSB +: 2];
  assign tc.attack_mult = state_ff.right_cfg[ATC_MULT_LSB +: 3];

  atc_time_calc u_calc (
    .tc(tc.calc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register writes, read data and the effective times.
  always_comb begin
    nxt_state = state_ff;
    left_pick = legacy_left_decay_ms;
    // Writes store the whole byte; the low two bits are kept as written
    // and the host is trusted to leave them zero, since masking them here
    // would hide a host fault that a read-back can otherwise reveal.
    if (reg_wr) begin
      if (reg_addr == ATC_LEFT_DECAY_OFS) begin
        nxt_state.left_cfg = reg_wdata;
      end else if (reg_addr == ATC_RIGHT_ATTACK_OFS) begin
        nxt_state.right_cfg = reg_wdata;
      end
    end
    // Reads answer one edge later; unmapped offsets read as zero.
    if (reg_rd) begin
      if (reg_addr == ATC_LEFT_DECAY_OFS) begin
        nxt_state.rdata = state_ff.left_cfg;
      end else if (reg_addr == ATC_RIGHT_ATTACK_OFS) begin
        nxt_state.rdata = state_ff.right_cfg;
      end else begin
        nxt_state.rdata = ATC_RDATA_RST;
      end
    end
    // Source select, then the cap; the cap also guards legacy times,
    // since the engine cannot run longer whichever register sets it.
    if (state_ff.left_cfg[ATC_SEL_BIT]) begin
      left_pick = tc.decay_ms;
    end
    nxt_state.left_decay = atc_limit(left_pick, adc_decimation_ratio);
    // The right attack time has no cap, so it passes straight through.
    if (state_ff.right_cfg[ATC_SEL_BIT]) begin
      nxt_state.right_attack = tc.attack_ms;
    end else begin
      nxt_state.right_attack = legacy_right_attack_ms;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every field clears on reset, so the legacy registers rule at first.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= '{left_cfg: ATC_CFG_RST, right_cfg: ATC_CFG_RST,
                    rdata: ATC_RDATA_RST, left_decay: ATC_TIME_RST,
                    right_attack: ATC_TIME_RST};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Every output is a field of the state flip-flops, with no logic after.
  assign reg_rdata = state_ff.rdata;
  assign left_decay_ms = state_ff.left_decay;
  assign right_attack_ms = state_ff.right_attack;

  ////////////////////////////////////////////////////////////////////////////
  // Checks. Register fields as seen by the checks.
  logic l_sel; // Left source select.
  logic r_sel; // Right source select.
  logic [1:0] l_base; // Left baseline code.
  logic [2:0] l_mult; // Left multiplier code.
  logic [1:0] r_base; // Right baseline code.
  logic [2:0] r_mult; // Right multiplier code.
  assign l_sel = state_ff.left_cfg[ATC_SEL_BIT];
  assign r_sel = state_ff.right_cfg[ATC_SEL_BIT];
  assign l_base = state_ff.left_cfg[ATC_BASE_LSB +: 2];
  assign l_mult = state_ff.left_cfg[ATC_MULT_LSB +: 3];
  assign r_base = state_ff.right_cfg[ATC_BASE_LSB +: 2];
  assign r_mult = state_ff.right_cfg[ATC_MULT_LSB +: 3];

  // A write to a register, then a read of the same register.
  sequence left_wr_s;
    reg_wr && !reg_rd && reg_addr == ATC_LEFT_DECAY_OFS;
  endsequence
  sequence left_rd_s;
    !reg_wr && reg_rd && reg_addr == ATC_LEFT_DECAY_OFS;
  endsequence

  // Legacy left time, capped; the release edge itself is skipped, since
  // the outputs still hold their reset value one edge later.
  legacy_left_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && !l_sel |=> left_decay_ms ==
      atc_limit($past(legacy_left_decay_ms), $past(adc_decimation_ratio)))
    else $error("Left decay does not follow the legacy time.");

  // With a factor of one the baseline decay time shows unchanged.
  decay_base_a: assert property (@(posedge clk) disable iff (sys_rst)
    l_sel && l_mult == 3'h0
    |=> left_decay_ms == ATC_DECAY_BASE_MS[$past(l_base)])
    else $error("Left baseline decay time is wrong.");

  // Under the top cap, the shortest base shows every factor uncut.
  decay_mult_a: assert property (@(posedge clk) disable iff (sys_rst)
    l_sel && l_base == 2'h0 && adc_decimation_ratio == 4'ha
    |=> left_decay_ms == (16'h0032 << $past(l_mult)))
    else $error("Left decay multiplier is wrong.");

  // The longest programmed decay meets the cap of the two lowest ratios.
  cap_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    l_sel && l_base == 2'h3 && l_mult == 3'h7 && adc_decimation_ratio < 4'h2
    |=> left_decay_ms == ($past(adc_decimation_ratio) == 4'h0 ?
                          16'h0fa0 : 16'h15e0))
    else $error("Decay cap for ratios 1 and 1.5 is wrong.");

  // Ratios 2 and 2.5 have caps of their own.
  cap_two_a: assert property (@(posedge clk) disable iff (sys_rst)
    l_sel && l_base == 2'h3 && l_mult == 3'h7 &&
    adc_decimation_ratio inside {4'h2, 4'h3}
    |=> left_decay_ms == ($past(adc_decimation_ratio) == 4'h2 ?
                          16'h1f40 : 16'h2580))
    else $error("Decay cap for ratios 2 and 2.5 is wrong.");

  // Ratio 3.5 shares the cap of ratio 3.
  cap_mid_a: assert property (@(posedge clk) disable iff (sys_rst)
    l_sel && l_base == 2'h3 && l_mult == 3'h7 && adc_decimation_ratio == 4'h5
    |=> left_decay_ms == 16'h2bc0)
    else $error("Decay cap for ratio 3.5 is wrong.");

  // Ratio 5 has a cap of its own.
  cap_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    l_sel && l_base == 2'h3 && l_mult == 3'h7 && adc_decimation_ratio == 4'h8
    |=> left_decay_ms == 16'h4b00)
    else $error("Decay cap for ratio 5 is wrong.");

  // Ratios 4 and 4.5 share one cap.
  cap_four_a: assert property (@(posedge clk) disable iff (sys_rst)
    l_sel && l_base == 2'h3 && l_mult == 3'h7 &&
    adc_decimation_ratio inside {4'h6, 4'h7}
    |=> left_decay_ms == 16'h3e80)
    else $error("Decay cap for ratios 4 and 4.5 is wrong.");

  // Ratios 5.5 and 6, and the unused codes above them, share the top cap.
  cap_top_a: assert property (@(posedge clk) disable iff (sys_rst)
    l_sel && l_base == 2'h3 && l_mult == 3'h7 &&
    adc_decimation_ratio > 4'h8
    |=> left_decay_ms == 16'h5780)
    else $error("Decay cap for the top ratios is wrong.");

  // Legacy right time passes through; the release edge is skipped.
  legacy_right_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && !r_sel |=> right_attack_ms == $past(legacy_right_attack_ms))
    else $error("Right attack does not follow the legacy time.");

  // With a factor of one the baseline attack time shows unchanged.
  attack_base_a: assert property (@(posedge clk) disable iff (sys_rst)
    r_sel && r_mult == 3'h0
    |=> right_attack_ms == ATC_ATTACK_BASE_MS[$past(r_base)])
    else $error("Right baseline attack time is wrong.");

  // The longest base shows every attack factor.
  attack_mult_a: assert property (@(posedge clk) disable iff (sys_rst)
    r_sel && r_base == 2'h3 |=> right_attack_ms == (16'h000b << $past(r_mult)))
    else $error("Right attack multiplier is wrong.");

  // A read right after a write already returns the new byte.
  write_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    left_wr_s ##1 left_rd_s |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Left register does not read back the written byte.");

  // An edge seen in reset leaves both registers cleared one edge later.
  reset_zero_a: assert property (@(posedge clk)
    sys_rst |=> state_ff.left_cfg == 8'h00 && state_ff.right_cfg == 8'h00)
    else $error("Timing registers are not zero after reset.");

endmodule

// file: tb/test_atc_regs.sv
module test_atc_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import atc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals; the stimulus is given a value at time zero.
  logic clk = 1'b0; // Control clock, 50 ns period.
  logic sys_rst = 1'b1; // Held high for the first 12 cycles.
  logic reg_wr = 1'b0; // Write strobe.
  logic reg_rd = 1'b0; // Read strobe.
  logic [6:0] reg_addr = 7'h00; // Register offset.
  logic [7:0] reg_wdata = 8'h00; // Write byte.
  logic [7:0] reg_rdata; // Read byte.
  logic [15:0] legacy_left_decay_ms = 16'h03e8; // Legacy left time, 1 s.
  logic [15:0] legacy_right_attack_ms = 16'h0007; // Legacy right time.
  logic [3:0] adc_decimation_ratio = 4'ha; // Largest ratio by default.
  logic [15:0] left_decay_ms; // Effective left decay time.
  logic [15:0] right_attack_ms; // Effective right attack time.
  int err_count = 0; // Mismatches seen.
  int comparisons = 0; // Comparisons made.
  logic [7:0] rb; // Byte read back.
  // Expected baseline and cap tables in milliseconds, kept apart from the
  // design so that a wrong table on either side shows up.
  logic [15:0] dbase [4] = '{16'h0032, 16'h0096, 16'h00fa, 16'h015e};
  logic [15:0] abase [4] = '{16'h0007, 16'h0008, 16'h000a, 16'h000b};
  logic [15:0] caps [11] = '{16'h0fa0, 16'h15e0, 16'h1f40, 16'h2580,
    16'h2bc0, 16'h2bc0, 16'h3e80, 16'h3e80, 16'h4b00, 16'h5780, 16'h5780};
  logic [15:0] e; // Scratch expectation.

  atc_regs u_atc_regs (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .legacy_left_decay_ms(legacy_left_decay_ms),
    .legacy_right_attack_ms(legacy_right_attack_ms),
    .adc_decimation_ratio(adc_decimation_ratio),
    .left_decay_ms(left_decay_ms), .right_attack_ms(right_attack_ms));

  // The clock toggles every half period.
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it; a mismatch is reported at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write; the bench always clears the two low bits.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= {d[7:2], 2'b00};
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // One read; the byte is taken one edge after the read edge.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, and the legacy times in effect straight after reset.
  task automatic t_reset();
    rd(7'h68, rb);
    chk({8'h00, rb}, 16'h0000);
    rd(7'h69, rb);
    chk({8'h00, rb}, 16'h0000);
    chk(left_decay_ms, 16'h03e8);
    chk(right_attack_ms, 16'h0007);
    $display("t_reset done");
  endtask

  // Every baseline code with every multiplier, on both registers.
  task automatic t_codes();
    for (int b = 0; b < 4; b++) begin
      for (int m = 0; m < 8; m++) begin
        wr(7'h68, {1'b1, 2'(b), 3'(m), 2'b00});
        wr(7'h69, {1'b1, 2'(b), 3'(m), 2'b00});
        e = dbase[b] << m;
        chk(left_decay_ms, (e > caps[10]) ? caps[10] : e);
        chk(right_attack_ms, 16'(abase[b] << m));
        rd(7'h69, rb);
        chk({8'h00, rb}, {8'h00, 1'b1, 2'(b), 3'(m), 2'b00});
      end
    end
    $display("t_codes done");
  endtask

  // Longest decay time against every ratio code.
  task automatic t_caps();
    wr(7'h68, 8'hfc);
    // Codes past the last ratio must act as the last ratio.
    for (int r = 0; r < 16; r++) begin
      @(posedge clk);
      adc_decimation_ratio <= 4'(r);
      repeat (2) @(posedge clk);
      #1;
      chk(left_decay_ms, caps[(r > 10) ? 10 : r]);
    end
    $display("t_caps done");
  endtask

  // Select bits cleared with fields set: legacy times are followed.
  task automatic t_legacy();
    wr(7'h68, 8'h7c);
    wr(7'h69, 8'h7c);
    @(posedge clk);
    legacy_left_decay_ms <= 16'h0123;
    legacy_right_attack_ms <= 16'h0456;
    repeat (2) @(posedge clk);
    #1;
    chk(left_decay_ms, 16'h0123);
    chk(right_attack_ms, 16'h0456);
    // A write to an unmapped offset must leave the left register alone.
    wr(7'h6a, 8'hfc);
    rd(7'h6a, rb);
    chk({8'h00, rb}, 16'h0000);
    rd(7'h68, rb);
    chk({8'h00, rb}, 16'h007c);
    $display("t_legacy done");
  endtask

  // A write and a read of the left register on consecutive edges.
  task automatic t_back();
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= 7'h68;
    reg_wdata <= 8'ha4;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, 16'h00a4);
    chk(left_decay_ms, 16'h012c);
    $display("t_back done");
  endtask

  // A reset in mid-run clears both registers; legacy times rule again.
  task automatic t_rerst();
    wr(7'h68, 8'hfc);
    wr(7'h69, 8'hfc);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(left_decay_ms, 16'h0123);
    chk(right_attack_ms, 16'h0456);
    rd(7'h68, rb);
    chk({8'h00, rb}, 16'h0000);
    rd(7'h69, rb);
    chk({8'h00, rb}, 16'h0000);
    $display("t_rerst done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 12 cycles, then each scenario in turn.
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_codes();
    t_caps();
    t_back();
    t_legacy();
    t_rerst();
    final_report();
  end

  // Cuts a hang short; the limit is far above the run's real length.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule
